// >>> logic/ocp_top.sv
// charge overcurrent / short-circuit detection, fault flags, FET control
// assumes sense_mv from an ADC on mclk; charger pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
module ocp_top
    import ocp_pkg::*;
#(
    parameter logic [32:0] CYC_PER_MS_P    = 33'(CYC_PER_MS_L),
    parameter logic [32:0] CYC_PER_S_P     = 33'(CYC_PER_S_L),
    parameter logic [32:0] CYC_PER_MIN_P   = 33'(CYC_PER_MIN_L),
    parameter logic [31:0] MON_DELAY_CYC   = 32'(CYC_PER_S_L * MON_DELAY_S),
    parameter logic [31:0] PROBE_PERIOD_CYC =
        32'(CYC_PER_MS_L * PROBE_PERIOD_MS)
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata_ff,
    input  wire logic [9:0] sense_mv,
    input  wire logic       charger_sense_pin,
    input  wire logic [3:0] charger_probe_pulse_width,
    input  wire logic       host_fet_control,
    input  wire logic       host_charger_monitor_override,
    input  wire logic       charger_probe_enable,
    input  wire logic       charge_error_clear,
    input  wire logic       charge_switch_enable,
    input  wire logic       discharge_switch_enable,
    input  wire logic       short_fault_clear,
    input  wire logic       other_fault,
    output logic            charge_overcurrent_fault,
    output logic            short_circuit_fault,
    output logic            charger_present,
    output logic            load_present,
    output logic            charge_fet_on,
    output logic            discharge_fet_on,
    output logic            charger_probe_drive
);
    logic [7:0]  chg_dly_lo_ff;
    logic [7:0]  chg_ctrl_ff;
    logic [7:0]  sht_dly_lo_ff;
    logic [7:0]  sht_ctrl_ff;
    logic [9:0]  chg_thr_mv;
    logic [9:0]  sht_thr_mv;
    logic        chg_trip;
    logic        sht_trip;
    logic        sense_lvl;
    logic        coc_ff;
    logic        dsc_ff;
    logic        chp_ff;
    logic        ldp_ff;
    logic        host_fet_control_ff;
    logic        discharge_switch_enable_ff;
    logic        probe_ff;
    logic [1:0]  absent_ff;
    logic [31:0] cnt_ff;
    logic [31:0] pw_cyc;
    logic        pulse_end;
    logic        period_end;
    logic        recover;
    ocp_state_t  state_ff;
    ocp_state_t  nxt_state;

    function automatic logic [9:0] chg_mv(input logic [2:0] code);
        case (code)
            3'h0:    chg_mv = 10'h001;
            3'h1:    chg_mv = 10'h002;
            3'h2:    chg_mv = 10'h004;
            3'h3:    chg_mv = 10'h006;
            3'h4:    chg_mv = 10'h008;
            3'h5:    chg_mv = 10'h00C;
            3'h6:    chg_mv = 10'h010;
            default: chg_mv = 10'h018;
        endcase
    endfunction : chg_mv

    function automatic logic [9:0] sht_mv(input logic [2:0] code);
        case (code)
            3'h0:    sht_mv = 10'h010;
            3'h1:    sht_mv = 10'h018;
            3'h2:    sht_mv = 10'h020;
            3'h3:    sht_mv = 10'h030;
            3'h4:    sht_mv = 10'h040;
            3'h5:    sht_mv = 10'h060;
            3'h6:    sht_mv = 10'h080;
            default: sht_mv = 10'h100;
        endcase
    endfunction : sht_mv

    // register port; the reserved top control bit is never stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            chg_dly_lo_ff <= RST_CHG_DLY_LO;
            chg_ctrl_ff   <= RST_CHG_CTRL;
            sht_dly_lo_ff <= RST_SHT_DLY_LO;
            sht_ctrl_ff   <= RST_SHT_CTRL;
        end else if (reg_wr) begin
            if (reg_addr == OFS_CHG_DLY_LO) begin
                chg_dly_lo_ff <= reg_wdata;
            end else if (reg_addr == OFS_CHG_CTRL) begin
                chg_ctrl_ff <= reg_wdata & CTRL_RW_MASK;
            end else if (reg_addr == OFS_SHT_DLY_LO) begin
                sht_dly_lo_ff <= reg_wdata;
            end else if (reg_addr == OFS_SHT_CTRL) begin
                sht_ctrl_ff <= reg_wdata & CTRL_RW_MASK;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == OFS_CHG_DLY_LO) begin
                reg_rdata_ff <= chg_dly_lo_ff;
            end else if (reg_addr == OFS_CHG_CTRL) begin
                reg_rdata_ff <= chg_ctrl_ff;
            end else if (reg_addr == OFS_SHT_DLY_LO) begin
                reg_rdata_ff <= sht_dly_lo_ff;
            end else if (reg_addr == OFS_SHT_CTRL) begin
                reg_rdata_ff <= sht_ctrl_ff;
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    assign chg_thr_mv = chg_mv(chg_ctrl_ff[THR_HI:THR_LO]);
    assign sht_thr_mv = sht_mv(sht_ctrl_ff[THR_HI:THR_LO]);

    ocp_trip_timer #(
        .CYC_PER_MS  (CYC_PER_MS_P),
        .CYC_PER_S   (CYC_PER_S_P),
        .CYC_PER_MIN (CYC_PER_MIN_P)
    ) u_chg_timer (
        .mclk    (mclk),
        .rst     (rst),
        .over    (sense_mv > chg_thr_mv),
        .unit    (chg_ctrl_ff[UNIT_HI:UNIT_LO]),
        .delay   ({chg_ctrl_ff[DLY_HI:0], chg_dly_lo_ff}),
        .trip_ff (chg_trip)
    );

    ocp_trip_timer #(
        .CYC_PER_MS  (CYC_PER_MS_P),
        .CYC_PER_S   (CYC_PER_S_P),
        .CYC_PER_MIN (CYC_PER_MIN_P)
    ) u_sht_timer (
        .mclk    (mclk),
        .rst     (rst),
        .over    (sense_mv > sht_thr_mv),
        .unit    (sht_ctrl_ff[UNIT_HI:UNIT_LO]),
        .delay   ({sht_ctrl_ff[DLY_HI:0], sht_dly_lo_ff}),
        .trip_ff (sht_trip)
    );

    ocp_sync3 u_sense_sync (
        .mclk     (mclk),
        .rst      (rst),
        .pin      (charger_sense_pin),
        .level_ff (sense_lvl)
    );

    // a zero width still gives a one millisecond probe
    assign pw_cyc = 32'(((charger_probe_pulse_width == 4'h0) ? 4'h1 :
                         charger_probe_pulse_width) * CYC_PER_MS_P);
    assign pulse_end  = (state_ff == ST_PULSE) && (cnt_ff == pw_cyc - 32'h1);
    assign period_end = (state_ff == ST_GAP) &&
                        (cnt_ff == PROBE_PERIOD_CYC - 32'h1);
    assign recover = period_end && !host_fet_control &&
                     (absent_ff >= 2'(ABSENT_LIMIT));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (coc_ff && !host_charger_monitor_override) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_ff == MON_DELAY_CYC - 32'h1) begin
                    nxt_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (pulse_end) begin
                    nxt_state = ST_GAP;
                end
            end
            default: begin
                if (recover || !coc_ff) begin
                    nxt_state = ST_IDLE;
                end else if (period_end) begin
                    nxt_state = ST_PULSE;
                end
            end
        endcase
        // override hands monitoring to the host at once
        if (host_charger_monitor_override) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // cnt runs through hold, then through each 256 ms period from pulse start
    always_ff @(posedge mclk) begin
        if (rst || state_ff == ST_IDLE) begin
            cnt_ff <= 32'h0;
        end else if (nxt_state != state_ff && state_ff != ST_PULSE) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // consecutive probe periods with no charger seen
    always_ff @(posedge mclk) begin
        if (rst || state_ff == ST_IDLE) begin
            absent_ff <= 2'h0;
        end else if (pulse_end) begin
            if (sense_lvl) begin
                absent_ff <= 2'h0;
            end else if (absent_ff != 2'h3) begin
                absent_ff <= absent_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            probe_ff <= 1'b0;
        end else if (host_charger_monitor_override) begin
            probe_ff <= charger_probe_enable;
        end else begin
            probe_ff <= (nxt_state == ST_PULSE);
        end
    end

    // set wins over clear for every fault and presence flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            coc_ff <= 1'b0;
        end else if (chg_trip) begin
            coc_ff <= 1'b1;
        end else if (recover) begin
            coc_ff <= 1'b0;
        end else if (host_charger_monitor_override && charge_error_clear) begin
            coc_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            chp_ff <= 1'b0;
        end else if (chg_trip) begin
            chp_ff <= 1'b1;
        end else if (host_charger_monitor_override && probe_ff) begin
            chp_ff <= sense_lvl;
        end else if (pulse_end) begin
            chp_ff <= sense_lvl;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dsc_ff <= 1'b0;
            ldp_ff <= 1'b0;
        end else if (sht_trip) begin
            dsc_ff <= 1'b1;
            ldp_ff <= 1'b1;
        end else if (short_fault_clear) begin
            dsc_ff <= 1'b0;
            ldp_ff <= 1'b0;
        end
    end

    // auto mode follows the faults; host mode follows the host bits except during a short fault
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_fet_control_ff <= 1'b0;
            discharge_switch_enable_ff <= 1'b0;
        end else if (sht_trip || dsc_ff) begin
            host_fet_control_ff <= 1'b0;
            discharge_switch_enable_ff <= 1'b0;
        end else if (host_fet_control) begin
            host_fet_control_ff <= charge_switch_enable;
            discharge_switch_enable_ff <= discharge_switch_enable;
        end else begin
            host_fet_control_ff <= !(chg_trip || coc_ff || other_fault);
            discharge_switch_enable_ff <= !(chg_trip || coc_ff || other_fault);
        end
    end

    assign charge_overcurrent_fault = coc_ff;
    assign short_circuit_fault      = dsc_ff;
    assign charger_present          = chp_ff;
    assign load_present             = ldp_ff;
    assign charge_fet_on            = host_fet_control_ff;
    assign discharge_fet_on         = discharge_switch_enable_ff;
    assign charger_probe_drive      = probe_ff;

    chg_trip_sets_a: assert property (@(posedge mclk) disable iff (rst)
        chg_trip |=> coc_ff && chp_ff)
        else $error("charge trip did not set fault and charger flags");
    chg_fet_off_a: assert property (@(posedge mclk) disable iff (rst)
        chg_trip && !host_fet_control |=> !host_fet_control_ff && !discharge_switch_enable_ff)
        else $error("FETs stayed on after charge trip");
    short_fet_off_a: assert property (@(posedge mclk) disable iff (rst)
        sht_trip |=> !host_fet_control_ff && !discharge_switch_enable_ff && dsc_ff && ldp_ff)
        else $error("short circuit did not force FETs off");
    sense_drop_a: assert property (@(posedge mclk) disable iff (rst)
        !(sense_mv > chg_thr_mv) |=> !chg_trip)
        else $error("charge timer not restarted on drop");
    hold_to_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        state_ff == ST_HOLD && nxt_state == ST_PULSE
        |-> cnt_ff == MON_DELAY_CYC - 32'h1)
        else $error("probing began before the monitor delay");
    probe_period_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(probe_ff) && $past(state_ff) == ST_GAP &&
        !$past(host_charger_monitor_override)
        |-> $past(cnt_ff) == PROBE_PERIOD_CYC - 32'h1)
        else $error("probe period wrong");
    probe_sample_a: assert property (@(posedge mclk) disable iff (rst)
        pulse_end && !chg_trip |=> chp_ff == $past(sense_lvl))
        else $error("charger flag did not follow sense pin");
    auto_recover_a: assert property (@(posedge mclk) disable iff (rst)
        recover && !chg_trip |=> !coc_ff)
        else $error("fault not cleared on recovery");
    recover_count_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(coc_ff) && !$past(host_charger_monitor_override)
        |-> $past(absent_ff) >= 2'(ABSENT_LIMIT))
        else $error("recovered before two empty periods");
    host_fet_a: assert property (@(posedge mclk) disable iff (rst)
        host_fet_control && !sht_trip && !dsc_ff
        |=> host_fet_control_ff == $past(charge_switch_enable))
        else $error("host FET bit not followed");
    reg_rsv_a: assert property (@(posedge mclk) disable iff (rst)
        !sht_ctrl_ff[7] && !chg_ctrl_ff[7])
        else $error("reserved control bit stored");

    chg_trip_c: cover property (@(posedge mclk) disable iff (rst) chg_trip);
    sht_trip_c: cover property (@(posedge mclk) disable iff (rst) sht_trip);
    recover_c:  cover property (@(posedge mclk) disable iff (rst) recover);
endmodule : ocp_top
`default_nettype wire

// >>> logic/ocp_pkg.sv
// constants for charge overcurrent and short-circuit protection
// assumes a single 100 MHz clock and a byte-wide register port
// How it works
// - charge threshold code picks 1,2,4,6,8,12,16,24 mV; default code 100.
// - charge time unit bits 3:2 pick us, ms (default), s, min.
// - charge delay count is 10 bits: low byte plus control bits 1:0.
// - charge fault only when sense stays over threshold longer than count times unit.
// - charge trip sets fault and charger flag; FETs off when host control clear.
// - charger monitor starts about 3 s later, probe pulse every 256 ms.
// - while probing, charger flag follows the sense pin comparison.
// - two probe periods without charger, host control clear: FETs back, fault cleared.
// - short threshold code picks 16,24,32,48,64,96,128,256 mV; default 110.
// - short time unit bits 3:2 pick us (default), ms, s, min.
// - short delay count is 10 bits: low byte plus control bits 1:0.
// - short over threshold for the delay sets short fault and load flag.
// - short circuit turns FETs off whatever the host control bit.
package ocp_pkg;
    localparam logic [7:0] OFS_CHG_DLY_LO = 8'h18;
    localparam logic [7:0] OFS_CHG_CTRL   = 8'h19;
    localparam logic [7:0] OFS_SHT_DLY_LO = 8'h1A;
    localparam logic [7:0] OFS_SHT_CTRL   = 8'h1B;
    localparam logic [7:0] RST_CHG_DLY_LO = 8'hA0;
    localparam logic [7:0] RST_CHG_CTRL   = 8'h44;
    localparam logic [7:0] RST_SHT_DLY_LO = 8'hC8;
    localparam logic [7:0] RST_SHT_CTRL   = 8'h60;
    localparam logic [7:0] CTRL_RW_MASK   = 8'h7F;
    localparam int THR_HI = 6;
    localparam int THR_LO = 4;
    localparam int UNIT_HI = 3;
    localparam int UNIT_LO = 2;
    localparam int DLY_HI = 1;
    localparam int ABSENT_LIMIT = 2;
    localparam int CLK_MHZ = 100;
    localparam int US_PER_MS = 1000;
    localparam int MS_PER_S = 1000;
    localparam int S_PER_MIN = 60;
    localparam int MON_DELAY_S = 3;
    localparam int PROBE_PERIOD_MS = 256;
    localparam longint CYC_PER_US_L = longint'(CLK_MHZ);
    localparam longint CYC_PER_MS_L = CYC_PER_US_L * US_PER_MS;
    localparam longint CYC_PER_S_L  = CYC_PER_MS_L * MS_PER_S;
    localparam longint CYC_PER_MIN_L = CYC_PER_S_L * S_PER_MIN;
    localparam logic [1:0] UNIT_US  = 2'h0;
    localparam logic [1:0] UNIT_MS  = 2'h1;
    localparam logic [1:0] UNIT_SEC = 2'h2;
    localparam logic [1:0] UNIT_MIN = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_HOLD  = 2'h1,
        ST_PULSE = 2'h3,
        ST_GAP   = 2'h2
    } ocp_state_t;
endpackage : ocp_pkg

// >>> logic/ocp_sync3.sv
// three-stage synchroniser for a pin level
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module ocp_sync3 (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level_ff
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            level_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end
endmodule : ocp_sync3
`default_nettype wire

// >>> logic/ocp_trip_timer.sv
// qualification timer: over-threshold held for count times unit
// assumes over is already in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module ocp_trip_timer
    import ocp_pkg::*;
#(
    parameter logic [32:0] CYC_PER_US  = 33'(CYC_PER_US_L),
    parameter logic [32:0] CYC_PER_MS  = 33'(CYC_PER_MS_L),
    parameter logic [32:0] CYC_PER_S   = 33'(CYC_PER_S_L),
    parameter logic [32:0] CYC_PER_MIN = 33'(CYC_PER_MIN_L)
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       over,
    input  wire logic [1:0] unit,
    input  wire logic [9:0] delay,
    output logic            trip_ff
);
    logic [32:0] sub_ff;
    logic [9:0]  units_ff;
    logic [32:0] unit_len;

    always_comb begin
        case (unit)
            UNIT_US:  unit_len = CYC_PER_US;
            UNIT_MS:  unit_len = CYC_PER_MS;
            UNIT_SEC: unit_len = CYC_PER_S;
            default:  unit_len = CYC_PER_MIN;
        endcase
    end

    // trip one cycle after delay full units, i.e. strictly longer
    always_ff @(posedge mclk) begin
        if (rst || !over) begin
            sub_ff   <= '0;
            units_ff <= '0;
            trip_ff  <= 1'b0;
        end else if (units_ff == delay) begin
            trip_ff <= 1'b1;
        end else if (sub_ff == unit_len - 33'h1) begin
            sub_ff   <= '0;
            units_ff <= units_ff + 10'h1;
        end else begin
            sub_ff <= sub_ff + 33'h1;
        end
    end
endmodule : ocp_trip_timer
`default_nettype wire

// >>> testbench/ocp_charger_model.sv
// charger node model as seen through the charger sense pin
// assumes probe comes from the block and attached from the bench
`timescale 1ns/1ps
`default_nettype none
module ocp_charger_model (
    input  wire logic mclk,
    input  wire logic probe,
    input  wire logic attached,
    output logic      charger_sense_pin
);
    logic float_ff = 1'b0;

    // an unprobed node wanders, so its level is only meaningful while probing
    always_ff @(posedge mclk) begin
        float_ff <= ~float_ff;
    end

    assign charger_sense_pin = probe ? attached : float_ff;
endmodule : ocp_charger_model
`default_nettype wire

// >>> testbench/ocp_top_tb.sv
// self-checking bench for ocp_top with a charger node model
// assumes time constants shortened through the top's parameters
`timescale 1ns/1ps
`default_nettype none
module ocp_top_tb
    import ocp_pkg::*;
;
    // unit lengths in cycles: us fixed, ms/s/min as set on the instance
    localparam int UC [4] = '{100, 5, 10, 20};
    localparam logic [9:0] CMV [8] = '{10'h001, 10'h002, 10'h004, 10'h006,
        10'h008, 10'h00C, 10'h010, 10'h018};
    localparam logic [9:0] SMV [8] = '{10'h010, 10'h018, 10'h020, 10'h030,
        10'h040, 10'h060, 10'h080, 10'h100};
    localparam logic [7:0] RSTV [4] = '{8'hA0, 8'h44, 8'hC8, 8'h60};

    logic       mclk = 1'b0;
    logic       rst;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [9:0] sense_mv;
    logic [3:0] charger_probe_pulse_width = 4'h2;
    logic       host_fet_control, host_charger_monitor_override;
    logic       charger_probe_enable, charge_error_clear, attached;
    logic       short_fault_clear, other_fault;
    logic       charge_switch_enable, discharge_switch_enable;
    wire logic [7:0] reg_rdata_ff;
    wire logic  charger_sense_pin, charger_probe_drive;
    wire logic  charge_overcurrent_fault, short_circuit_fault;
    wire logic  charger_present, load_present, charge_fet_on, discharge_fet_on;
    wire logic [5:0] flags = {charge_overcurrent_fault, short_circuit_fault,
        charger_present, load_present, charge_fet_on, discharge_fet_on};
    int         fails = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         n;
    int         w;

    ocp_charger_model partner (.mclk, .probe(charger_probe_drive), .attached,
        .charger_sense_pin);

    ocp_top #(
        .CYC_PER_MS_P(33'h5), .CYC_PER_S_P(33'hA), .CYC_PER_MIN_P(33'h14),
        .MON_DELAY_CYC(32'h32), .PROBE_PERIOD_CYC(32'h28)
    ) dut (
        .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
        .sense_mv, .charger_sense_pin, .charger_probe_pulse_width,
        .host_fet_control, .host_charger_monitor_override,
        .charger_probe_enable, .charge_error_clear, .charge_switch_enable,
        .discharge_switch_enable, .short_fault_clear, .other_fault,
        .charge_overcurrent_fault, .short_circuit_fault, .charger_present,
        .load_present, .charge_fet_on, .discharge_fet_on, .charger_probe_drive
    );

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chkf(input string nm, input logic [5:0] e, input logic [5:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chkf

    task automatic chkn(input string nm, input int e, input int g);
        n_checks++;
        if (g != e) begin
            fails++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chkn

    // inputs always move 1 ns after the edge, so nothing races the sampling
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        step(1);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        step(1);
        chk8(nm, e, reg_rdata_ff);
    endtask : rd

    task automatic do_reset();
        rst = 1'b1;
        sense_mv = 10'h000;
        {host_fet_control, host_charger_monitor_override, charger_probe_enable,
            charge_error_clear, short_fault_clear, other_fault, attached} = '0;
        {charge_switch_enable, discharge_switch_enable} = 2'b11;
        step(4);
        rst = 1'b0;
    endtask : do_reset

    task automatic run_len(input logic lvl, output int k);
        k = 0;
        while (charger_probe_drive === lvl && k < 300) begin
            step(1);
            k++;
        end
    endtask : run_len

    task automatic thr_trial(input bit sc, input logic [2:0] c, input logic [9:0] mv);
        do_reset();
        wr(sc ? OFS_SHT_DLY_LO : OFS_CHG_DLY_LO, 8'h00);
        wr(sc ? OFS_SHT_CTRL : OFS_CHG_CTRL, {1'b0, c, 4'h0});
        sense_mv = mv;
        step(20);
        chkf("equal to threshold", 6'b000011, flags);
        sense_mv = mv + 10'h001;
        step(4);
        chkf("trip flags", sc ? 6'b010100 : 6'b101000, flags);
    endtask : thr_trial

    task automatic tim_trial(input bit sc, input logic [1:0] u, input logic [9:0] d);
        int t;
        t = d * UC[u];
        do_reset();
        // short trials raise the charge threshold so only one detector runs
        if (sc)
            wr(OFS_CHG_CTRL, 8'h70);
        wr(sc ? OFS_SHT_DLY_LO : OFS_CHG_DLY_LO, d[7:0]);
        wr(sc ? OFS_SHT_CTRL : OFS_CHG_CTRL, {4'h0, u, d[9:8]});
        sense_mv = sc ? 10'h014 : 10'h004;
        step(t);
        sense_mv = 10'h000;
        step(3);
        chkf("held for delay only", 6'b000011, flags);
        sense_mv = sc ? 10'h014 : 10'h004;
        step(t + 4);
        chkf("held past delay", sc ? 6'b010100 : 6'b101000, flags);
    endtask : tim_trial

    initial begin
        do_reset();
        for (int i = 0; i < 4; i++)
            rd(8'h18 + 8'(i), RSTV[i], "reset value");
        rd(8'h1C, 8'h00, "unmapped read");
        wr(OFS_SHT_CTRL, 8'hFF);
        rd(OFS_SHT_CTRL, 8'h7F, "short control");
        wr(OFS_CHG_CTRL, 8'hFF);
        rd(OFS_CHG_CTRL, 8'h7F, "charge control");
        wr(OFS_CHG_DLY_LO, 8'h5A);
        rd(OFS_CHG_DLY_LO, 8'h5A, "charge delay low");
        wr(8'h1C, 8'h33);
        rd(8'h1C, 8'h00, "unmapped write");
        for (int i = 0; i < 8; i++) begin
            thr_trial(1'b0, 3'(i), CMV[i]);
            thr_trial(1'b1, 3'(i), SMV[i]);
        end
        for (int s = 0; s < 2; s++) begin
            for (int u = 0; u < 4; u++)
                tim_trial(s[0], 2'(u), 10'h002);
            tim_trial(s[0], 2'h1, 10'h100);
        end
        // automatic recovery with the charger first present, then removed
        do_reset();
        wr(OFS_CHG_DLY_LO, 8'h00);
        wr(OFS_CHG_CTRL, 8'h00);
        attached = 1'b1;
        sense_mv = 10'h004;
        step(2);
        sense_mv = 10'h000;
        run_len(1'b0, n);
        chkn("monitor hold window", 1, int'(n > 44 && n < 60));
        run_len(1'b1, w);
        chkn("probe width", 10, w);
        run_len(1'b0, n);
        chkn("probe period", 40, w + n);
        step(50);
        chkf("charger kept", 6'b101000, flags);
        attached = 1'b0;
        other_fault = 1'b1;
        n = 0;
        while (charge_overcurrent_fault !== 1'b0 && n < 300) begin
            step(1);
            n++;
        end
        chkn("two empty probes", 1, int'(n > 40 && n < 300));
        chkf("cleared, other fault", 6'b000000, flags);
        other_fault = 1'b0;
        step(2);
        chkf("fets back", 6'b000011, flags);
        // host owns the fets and the probing
        do_reset();
        {host_fet_control, host_charger_monitor_override} = 2'b11;
        wr(OFS_CHG_DLY_LO, 8'h00);
        wr(OFS_CHG_CTRL, 8'h00);
        sense_mv = 10'h004;
        step(2);
        sense_mv = 10'h000;
        step(2);
        chkf("host fets kept", 6'b101011, flags);
        {charge_switch_enable, discharge_switch_enable} = 2'b00;
        charger_probe_enable = 1'b1;
        step(12);
        charger_probe_enable = 1'b0;
        step(2);
        chkf("host probe", 6'b100000, flags);
        charge_error_clear = 1'b1;
        step(1);
        charge_error_clear = 1'b0;
        step(2);
        chkf("error cleared", 6'b000000, flags);
        {charge_switch_enable, discharge_switch_enable} = 2'b11;
        step(2);
        chkf("host fets on", 6'b000011, flags);
        wr(OFS_SHT_DLY_LO, 8'h00);
        sense_mv = 10'h0C8;
        step(3);
        sense_mv = 10'h000;
        step(1);
        chkf("short beats host", 6'b111100, flags);
        short_fault_clear = 1'b1;
        step(1);
        short_fault_clear = 1'b0;
        step(2);
        chkf("short cleared", 6'b101011, flags);
        give_verdict();
    end
endmodule : ocp_top_tb
`default_nettype wire
